// ==== shared/crps_pkg.sv ====
package crps_pkg;

  // Bus clock rate and derived periods.
  localparam int unsigned CLK_MHZ = 100;
  // Least power-on reset hold, in microseconds; the system must keep it.
  localparam int unsigned POR_HOLD_US = 2000;
  localparam int unsigned POR_HOLD_CYC = POR_HOLD_US * CLK_MHZ;
  // Bus outputs must be released within this many clocks of seeing reset.
  localparam int unsigned RELEASE_CLKS = 2;
  // Default length of the self-test run, in cycles.
  localparam int unsigned SELF_TEST_CYC = 64;
  // Default strap width.
  localparam int unsigned STRAP_W = 8;
  // Default cache line count to invalidate.
  localparam int unsigned CACHE_LINES = 16;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ    = 12'h008;
  localparam logic [11:0] OFS_MASK   = 12'h00C;
  localparam logic [11:0] OFS_STRAP  = 12'h010;

  // Control field positions.
  localparam int unsigned CTRL_DEEP_SLEEP = 0;
  localparam int unsigned CTRL_THROTTLE   = 1;
  localparam int unsigned CTRL_PROBE_OK   = 2;

  // Event bit positions in the sticky IRQ and mask registers.
  localparam int unsigned EV_RESET   = 0;
  localparam int unsigned EV_THERMAL = 1;
  localparam int unsigned EV_PROBE   = 2;
  localparam int unsigned EV_TEST    = 3;
  localparam int unsigned EV_W       = 4;

  // Reset values.
  localparam logic [2:0]  CTRL_RST = 3'h2;
  localparam logic [3:0]  MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    CRPS_RESET, CRPS_FLUSH, CRPS_SELF_TEST, CRPS_RUN, CRPS_HIZ
  } crps_state_t;

endpackage : crps_pkg

// ==== hw/crps_sync.sv ====
`timescale 1ns/1ns
// Two-flop synchroniser with a constant preset value under reset.
module crps_sync
  import crps_pkg::*;
#(
  parameter logic INIT = 1'b0
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic meta;
    logic sync;
  } crps_sync_t;

  crps_sync_t s_q;
  crps_sync_t s_d;

  // The first stage feeds only the second stage.
  always_comb
  begin
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  // Clock enable is deliberately not applied: a frozen block must still see reset arrive.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '{meta: INIT, sync: INIT};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;

endmodule : crps_sync

// ==== hw/crps_top.sv ====
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - While reset is active, return to known state and drop all cache lines.
// - Release all bus outputs to inactive within two clocks of seeing reset.
// - Power-status output low from one clock after deep sleep starts to one clock after it ends.
// - Thermal alarm active when sensor reports maximum temperature, throttling if enabled.
// - Probe-ready output low tells the debug tool debug operation is ready.
// - Soft-init active at reset release with sys-mgmt inactive runs built-in self test before execution.
// - System-management interrupt active at reset release tristates the three sideband outputs.
module crps_top
  import crps_pkg::*;
#(
  parameter int unsigned STRAPS  = STRAP_W,
  parameter int unsigned LINES   = CACHE_LINES,
  parameter int unsigned TEST_CY = SELF_TEST_CYC
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  input  wire logic               cpu_reset_n,
  input  wire logic               supply_ok,
  input  wire logic [STRAPS-1:0]  strap_in,
  input  wire logic               soft_init_n,
  input  wire logic               sys_mgmt_irq_n,
  input  wire logic               probe_request_n,
  input  wire logic               temp_max,
  input  wire logic               core_bus_drive,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    irq,
  output logic                    bus_out_en,
  output logic                    thermal_alarm_n,
  output logic                    thermal_alarm_oe,
  output logic                    power_status_n,
  output logic                    power_status_oe,
  output logic                    probe_ready_n,
  output logic                    probe_ready_oe,
  output logic                    built_in_self_test,
  output logic                    core_run,
  output logic [LINES-1:0]        cache_valid
);

  localparam int unsigned TW = $clog2(TEST_CY + 1);

  // Refuse shapes the registers cannot hold.
  initial
  begin
    if (STRAPS < 1 || STRAPS > 32 || LINES < 1 || TEST_CY < 1)
    begin
      $error("crps_top: unsupported parameter values");
    end
  end

  typedef struct packed {
    crps_state_t       st;
    logic              rst_prev;
    logic [STRAPS-1:0] strap;
    logic              soft_init;
    logic              hiz;
    logic [TW-1:0]     test_cnt;
    logic [LINES-1:0]  cache;
    logic [2:0]        ctrl;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   mask;
    logic [31:0]       rdata;
    logic              therm;
    logic              psleep;
    logic              pready_n;
  } crps_top_t;

  crps_top_t s_q;
  crps_top_t s_d;
  logic      rst_sync;
  logic      pg_sync;
  logic      in_reset;
  logic      acc;

  // Both asynchronous inputs cross into pclk before use.
  crps_sync #(.INIT(1'b0)) u_sync_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (cpu_reset_n),
    .dout    (rst_sync)
  );
  crps_sync #(.INIT(1'b0)) u_sync_pg (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (supply_ok),
    .dout    (pg_sync)
  );

  // Power-good low is folded into the internal reset.
  assign in_reset = !rst_sync || !pg_sync;
  assign acc      = psel && penable;

  function automatic logic [31:0] pad(input logic [31:0] v);
    pad = v;
  endfunction : pad

  // One next-state process for all state.
  always_comb
  begin
    s_d = s_q;
    s_d.rst_prev = in_reset;
    s_d.therm    = temp_max;
    s_d.psleep   = (s_q.st == CRPS_RUN) && s_q.ctrl[CTRL_DEEP_SLEEP];
    s_d.pready_n = !((s_q.st == CRPS_RUN) && s_q.ctrl[CTRL_PROBE_OK] && !probe_request_n);
    unique case (s_q.st)
      CRPS_RESET, CRPS_FLUSH:
      begin
        // Cache lines are dropped, never written back.
        s_d.cache = '0;
        s_d.st    = CRPS_FLUSH;
        if (!in_reset)
        begin
          // Straps, soft-init and sys-mgmt sampled at the release edge.
          s_d.strap     = strap_in;
          s_d.soft_init = !soft_init_n;
          s_d.hiz       = !sys_mgmt_irq_n;
          s_d.test_cnt  = '0;
          s_d.st        = !sys_mgmt_irq_n ? CRPS_HIZ
                        : (!soft_init_n ? CRPS_SELF_TEST : CRPS_RUN);
        end
      end
      CRPS_SELF_TEST:
      begin
        // Self test completes before execution starts.
        s_d.test_cnt = s_q.test_cnt + TW'(1);
        if (s_q.test_cnt == TW'(TEST_CY - 1))
        begin
          s_d.st = CRPS_RUN;
        end
      end
      CRPS_RUN:
      begin
        s_d.cache = {LINES{1'b1}};
      end
      CRPS_HIZ:
      begin
        s_d.st = CRPS_HIZ;
      end
      default:
      begin
        s_d.st = CRPS_RESET;
      end
    endcase
    if (in_reset)
    begin
      s_d.st    = CRPS_FLUSH;
      s_d.cache = '0;
      s_d.hiz   = 1'b0;
    end
    // Read data is registered; reading the event register clears it.
    s_d.rdata = '0;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OFS_CTRL:   s_d.rdata = pad({29'h0, s_q.ctrl});
        OFS_STATUS: s_d.rdata = pad({27'h0, s_q.st == CRPS_RUN, s_q.hiz, s_q.soft_init,
                                     !s_q.pready_n, s_q.psleep});
        OFS_IRQ:    s_d.rdata = pad({28'h0, s_q.ev});
        OFS_MASK:   s_d.rdata = pad({28'h0, s_q.mask});
        OFS_STRAP:  s_d.rdata = pad(32'(s_q.strap));
        default:    s_d.rdata = '0;
      endcase
    end
    if (acc && pwrite && paddr == OFS_CTRL)
    begin
      s_d.ctrl = pwdata[2:0];
    end
    if (acc && pwrite && paddr == OFS_MASK)
    begin
      s_d.mask = pwdata[EV_W-1:0];
    end
    if (acc && !pwrite && paddr == OFS_IRQ)
    begin
      s_d.ev = '0;
    end
    // Events set after the clear so a same-cycle event is kept.
    if (in_reset && !s_q.rst_prev)
    begin
      s_d.ev[EV_RESET] = 1'b1;
    end
    if (temp_max && !s_q.therm)
    begin
      s_d.ev[EV_THERMAL] = 1'b1;
    end
    if (!probe_request_n && s_q.pready_n && !s_d.pready_n)
    begin
      s_d.ev[EV_PROBE] = 1'b1;
    end
    if (s_q.st == CRPS_SELF_TEST && s_d.st == CRPS_RUN)
    begin
      s_d.ev[EV_TEST] = 1'b1;
    end
  end

  // State freezes while clk_en is low; asynchronous reset loads constants only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q          <= '0;
      s_q.st       <= CRPS_RESET;
      s_q.rst_prev <= 1'b1;
      s_q.ctrl     <= CTRL_RST;
      s_q.mask     <= MASK_RST;
      s_q.pready_n <= 1'b1;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // Zero-wait APB slave; unmapped reads return zero without error.
  assign prdata  = s_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign irq     = |(s_q.ev & s_q.mask);

  // Bus drive stops once reset is synchronised; that is inside two clocks.
  assign bus_out_en = core_bus_drive && !in_reset && s_q.st == CRPS_RUN;
  // Sideband pins float when the sys-mgmt strap asked for tristate.
  assign thermal_alarm_oe = !s_q.hiz;
  assign power_status_oe  = !s_q.hiz;
  assign probe_ready_oe   = !s_q.hiz;
  // Alarm tracks the sensor; throttling follows only when enabled.
  assign thermal_alarm_n  = !s_q.therm;
  // Low from one edge after the core enters deep sleep to one edge after it leaves.
  assign power_status_n   = !s_q.psleep;
  // Ready is answered to a held probe request once debug is allowed.
  assign probe_ready_n    = s_q.pready_n;
  assign built_in_self_test = s_q.st == CRPS_SELF_TEST;
  assign core_run         = s_q.st == CRPS_RUN && !(s_q.therm && s_q.ctrl[CTRL_THROTTLE]);
  assign cache_valid      = s_q.cache;

  // No line may stay valid once an enabled edge has seen reset.
  a_cache_drop: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && in_reset |=> cache_valid == '0)
    else $error("cache not invalidated in reset");

  // The synchroniser uses the whole two-clock release budget, so no margin is left.
  a_bus_release: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cpu_reset_n) |-> ##2 !bus_out_en)
    else $error("bus outputs still driven two clocks after reset seen");

  // The straps seen at the releasing edge are the ones kept.
  a_strap_grab: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.st == CRPS_FLUSH && !in_reset |=> s_q.strap == $past(strap_in))
    else $error("straps not captured at release");

  // Straps stay frozen while running, so pins moving after release never leak in.
  a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.st == CRPS_RUN && !in_reset |=> $stable(s_q.strap))
    else $error("straps changed after release");

  // Deep sleep in the run state shows on the status pin one edge later.
  a_sleep_pin: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.st == CRPS_RUN && s_q.ctrl[CTRL_DEEP_SLEEP] && !in_reset
    |=> !power_status_n)
    else $error("power status not asserted in deep sleep");

  // The alarm pin follows the sensor one enabled edge later.
  a_therm_pin: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && temp_max |=> !thermal_alarm_n)
    else $error("thermal alarm missing");

  // A rising alarm must survive a read of the event register in the same cycle.
  a_therm_event: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && temp_max && !s_q.therm |=> s_q.ev[EV_THERMAL])
    else $error("thermal event lost");

  // Ready only answers a request seen on the previous enabled edge.
  a_probe_ack: assert property (@(posedge pclk) disable iff (!presetn)
    $past(clk_en) && !probe_ready_n |-> !$past(probe_request_n))
    else $error("probe ready without request");

  // Outside the run state, or while debug is not allowed, a request is refused.
  a_probe_gate: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !(s_q.st == CRPS_RUN && s_q.ctrl[CTRL_PROBE_OK]) |=> probe_ready_n)
    else $error("probe ready given while debug not allowed");

  // Soft-init low at release, with no sys-mgmt request, sends the core into self test first.
  a_test_run: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.st == CRPS_FLUSH && !in_reset && sys_mgmt_irq_n && !soft_init_n
    |=> built_in_self_test)
    else $error("self test not started");

  // The self test runs its full count and only then hands over to execution.
  a_test_end: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && built_in_self_test && !in_reset && s_q.test_cnt == TW'(TEST_CY - 1)
    |=> !built_in_self_test && s_q.st == CRPS_RUN)
    else $error("self test did not end into execution");

  // A sys-mgmt request at release floats every sideband pin.
  a_hiz_pins: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && s_q.st == CRPS_FLUSH && !in_reset && !sys_mgmt_irq_n
    |=> !thermal_alarm_oe && !probe_ready_oe && !power_status_oe)
    else $error("outputs not tristated");

  // Losing power-good stops execution and bus drive like a reset.
  a_pg_reset: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !pg_sync |=> !core_run && !bus_out_en)
    else $error("power-good low did not reset");

endmodule : crps_top

// ==== hw/unused_placeholder_none.sv ====
`timescale 1ns/1ns

// ==== verif/crps_partner.sv ====
`timescale 1ns/1ns
// Stands in for the power supervisor, the system logic and the debug tool.
module crps_partner
#(
  parameter int unsigned POR_CYC = 20,
  parameter logic [7:0]  STRAP_V = 8'hA5
)(
  input  wire logic       pclk,
  input  wire logic       pwr_req,
  input  wire logic       rst_req,
  input  wire logic       dbg_req,
  output logic            supply_ok,
  output logic            cpu_reset_n,
  output logic            probe_request_n,
  output logic [7:0]      strap_in
);
  int unsigned hold_q;
  // Power-good is low until asked for, then one clean edge.
  assign supply_ok = pwr_req;
  // Straps never move, so they are settled long before any release.
  assign strap_in = STRAP_V;
  // The debug tool pulls its request low to ask for debug operation.
  assign probe_request_n = !dbg_req;
  // The power-on hold is scaled down so that runs stay short.
  always_ff @(posedge pclk)
  begin
    if (!pwr_req || rst_req)
    begin
      hold_q <= 0;
    end
    else if (hold_q < POR_CYC)
    begin
      hold_q <= hold_q + 1;
    end
  end
  assign cpu_reset_n = pwr_req && !rst_req && (hold_q == POR_CYC);
endmodule : crps_partner

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb;
  import crps_pkg::*;
  typedef struct {logic we; logic [11:0] a; logic [31:0] d;} crps_row_t;
  logic pclk, presetn, pwr, rst, dbg, soft_n, smi_n, hot, drive, en, rsp;
  logic psel, penable, pwrite, pready, pslverr, irq, bus_out_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic supply_ok, cpu_reset_n, probe_request_n, built_in_self_test, core_run;
  logic [7:0] strap_in;
  logic [15:0] cache_valid;
  logic thermal_alarm_n, thermal_alarm_oe, power_status_n, power_status_oe;
  logic probe_ready_n, probe_ready_oe;
  int err_total = 0;
  int n_tests = 0;
  crps_row_t rows [8] = '{'{0, OFS_CTRL, {29'h0, CTRL_RST}}, '{0, OFS_MASK, 32'h0},
    '{0, OFS_STRAP, 32'hA5}, '{1, 12'h014, 32'hFFFFFFFF}, '{0, 12'h014, 32'h0},
    '{1, OFS_CTRL, 32'h5}, '{0, OFS_CTRL, 32'h5}, '{0, OFS_STATUS, 32'h11}};
  crps_partner crps_partner_inst (.pclk(pclk), .pwr_req(pwr), .rst_req(rst), .dbg_req(dbg),
    .supply_ok(supply_ok), .cpu_reset_n(cpu_reset_n),
    .probe_request_n(probe_request_n), .strap_in(strap_in));
  crps_top #(.TEST_CY(2)) crps_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(en),
    .cpu_reset_n(cpu_reset_n), .supply_ok(supply_ok), .strap_in(strap_in),
    .soft_init_n(soft_n), .sys_mgmt_irq_n(smi_n), .probe_request_n(probe_request_n),
    .temp_max(hot), .core_bus_drive(drive), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .bus_out_en(bus_out_en),
    .thermal_alarm_n(thermal_alarm_n), .thermal_alarm_oe(thermal_alarm_oe),
    .power_status_n(power_status_n), .power_status_oe(power_status_oe),
    .probe_ready_n(probe_ready_n), .probe_ready_oe(probe_ready_oe),
    .built_in_self_test(built_in_self_test), .core_run(core_run),
    .cache_valid(cache_valid));
  // Free-running bus clock at 100 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = !pclk;
  end
  // Compares a value seen with the one expected and counts both outcomes.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait has no limit of its own; only the watchdog ends it if pready never rises.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    rsp = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits out the scaled power-on hold plus the synchroniser delay.
  task settle();
    repeat (30) @(posedge pclk);
  endtask : settle
  task wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    wrap_up();
  end
  initial
  begin
    {presetn, pwr, rst, dbg, hot, psel, penable, pwrite} = '0;
    {soft_n, smi_n, drive, en} = 4'hF;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    chk({thermal_alarm_n, power_status_n, probe_ready_n, irq}, 4'hE);
    presetn <= 1'b1;
    pwr <= 1'b1;
    settle();
    // Table of register accesses after a plain power-on release.
    foreach (rows[i])
    begin
      apb(rows[i].we, rows[i].a, rows[i].d);
      if (!rows[i].we)
        chk(rd, rows[i].d);
      chk(rsp, 1'b0);
    end
    $display("register table done");
    repeat (3) @(posedge pclk);
    chk(power_status_n, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h4);
    repeat (3) @(posedge pclk);
    chk(power_status_n, 1'b1);
    $display("deep sleep done");
    hot <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(thermal_alarm_n, 1'b0);
    chk(core_run, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h6);
    repeat (2) @(posedge pclk);
    chk(core_run, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h4);
    chk(irq, 1'b0);
    apb(1'b1, OFS_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b0, OFS_IRQ, 32'h0);
    chk(rd & 32'h2, 32'h2);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    hot <= 1'b0;
    repeat (2) @(posedge pclk);
    // A low clock enable must hold the alarm pin where it was.
    en <= 1'b0;
    hot <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(thermal_alarm_n, 1'b1);
    en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(thermal_alarm_n, 1'b0);
    hot <= 1'b0;
    $display("thermal done");
    dbg <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(probe_ready_n, 1'b0);
    dbg <= 1'b0;
    $display("probe done");
    // Warm reset: outputs let go, caches dropped, then self test on release.
    chk(bus_out_en, 1'b1);
    rst <= 1'b1;
    soft_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(bus_out_en, 1'b0);
    chk(cache_valid, 16'h0);
    rst <= 1'b0;
    for (int i = 0; i < 100 && built_in_self_test !== 1'b1; i++) @(posedge pclk);
    chk({built_in_self_test, core_run}, 2'h2);
    soft_n <= 1'b1;
    for (int i = 0; i < 100 && core_run !== 1'b1; i++) @(posedge pclk);
    chk(core_run, 1'b1);
    $display("reset and self test done");
    rst <= 1'b1;
    smi_n <= 1'b0;
    repeat (6) @(posedge pclk);
    rst <= 1'b0;
    settle();
    chk({thermal_alarm_oe, power_status_oe, probe_ready_oe, bus_out_en}, 4'h0);
    smi_n <= 1'b1;
    $display("tristate done");
    // Dropping power-good acts as reset and restores driven idle outputs.
    pwr <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({thermal_alarm_oe, power_status_oe, probe_ready_oe}, 3'h7);
    chk(cache_valid, 16'h0);
    $display("supply drop done");
    wrap_up();
  end
endmodule : tb
